// ---- design/lks_device.sv ----
`timescale 1ns/10ps
// Behaviour
// - Hard reset low stops oscillator, clears data
// - Hard reset forces segment and backplane outputs low
// - Chip select low: serial traffic ignored
// - Bits move with the shift strobe
// - Serial output high-impedance while shifting in
// - One scan line driven high, others left undriven
// - 28 keys bare, 56 keys with diodes
// - Ratio 1/8: four lowest segments become backplanes
// - Auxiliary outputs drive full logic levels
// - Host sends display address within ratio range
// - Host sends highest backplane bit first
// - Shortened display writes keep sent bits
// - Bit 1 lit, bit 0 dark
// - Address 9: bias, lit, dark, run, aux levels
// - Ratio bit 0 quarter, 1 eighth
// - Run off stops, outputs low except aux pins and bias, data kept
// - Scan repeats every 32 oscillator periods
// - Chip select pulse after address arms readout
module lks_device #(
    parameter int OSC_DIV = lks_pkg::OSC_DIV_DEF
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    lks_link_if.dev          LINK,
    input  wire logic        I_EXT_TIMEBASE,
    input  wire logic [7:0]  I_KEY_SCAN_LINES,
    output logic      [7:0]  O_KEY_SCAN_LINES,
    output logic      [7:0]  O_KEY_SCAN_LINES_OE_N,
    output logic      [43:0] O_SEGMENT_LINES,
    output logic      [3:0]  O_BACKPLANE_DRIVES,
    output logic             O_BIAS_LADDER_STRENGTH
);
    if (OSC_DIV < 2 || OSC_DIV > 255) begin : g_chk
        $error("OSC_DIV out of range");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int SW = 13;
    logic [SW-1:0] s1_reg, s2_reg, s3_reg;
    wire  [SW-1:0] raw = {LINK.hard_reset_n, LINK.cs,
                          LINK.serial_shift_strobe, LINK.din,
                          I_EXT_TIMEBASE, I_KEY_SCAN_LINES};

    // Two stages, third only for edge detect
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            s1_reg <= {1'b1, {(SW-1){1'b0}}};
            s2_reg <= {1'b1, {(SW-1){1'b0}}};
            s3_reg <= {1'b1, {(SW-1){1'b0}}};
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    wire       hard   = ~s2_reg[12];
    wire       clr    = I_RESET | hard;
    wire       cs     = s2_reg[11];
    wire       cs_up  = s2_reg[11] & ~s3_reg[11];
    wire       cs_dn  = ~s2_reg[11] & s3_reg[11];
    wire       sck_up = cs & s2_reg[10] & ~s3_reg[10];
    wire       sck_dn = cs & ~s2_reg[10] & s3_reg[10];
    wire       din    = s2_reg[9];
    wire       tb_up  = s2_reg[8] & ~s3_reg[8];
    wire [7:0] key_in = s2_reg[7:0];

    // ------------------------------------------------------------
    // Serial receive
    // ------------------------------------------------------------
    logic [5:0] bit_reg;
    logic [3:0] addr_reg;
    logic [7:0] cfg_reg, ctl_reg;
    logic [7:0] lit_reg [lks_pkg::SEG_COUNT];
    logic       arm_reg, rd_reg;
    logic [39:0] out_sh_reg;

    wire        ratio   = cfg_reg[lks_pkg::CFG_RATIO];
    wire        run     = ctl_reg[lks_pkg::CTL_RUN];
    wire [5:0]  k       = bit_reg - 6'(lks_pkg::ADDR_BITS);
    wire        in_addr = bit_reg < 6'(lks_pkg::ADDR_BITS);
    wire        data_wr = sck_up & ~in_addr & ~rd_reg;
    wire        ctrl_k  = k < 6'(lks_pkg::CTRL_WIDTH);
    wire        cfg_wr  = data_wr & ctrl_k & (addr_reg == lks_pkg::ADDR_CFG);
    wire        ctl_wr  = data_wr & ctrl_k & (addr_reg == lks_pkg::ADDR_CTL);
    wire        cfg_keep = (k[2:0] == 3'd1) | (k[2:0] == 3'd2);
    wire        key_addr = (addr_reg == lks_pkg::ADDR_KEY_STD) |
                           (addr_reg == lks_pkg::ADDR_KEY_EXP);

    // Display bit position: highest backplane of top segment first
    logic        map_ok;
    logic [5:0]  map_seg;
    logic [2:0]  map_com;
    always_comb begin
        int a, top, bot, seg, per;
        a   = int'(addr_reg);
        per = ratio ? 8 : 4;
        top = ratio ? 8 + 5 * a : ((a == 4) ? 43 : 10 * a + 9);
        bot = ratio ? ((a == 0) ? 4 : top - 4) : 10 * a;
        seg = top - int'(k) / per;
        map_ok  = (addr_reg <= (ratio ? lks_pkg::ADDR_OCT_LAST
                                      : lks_pkg::ADDR_QUAD_LAST))
                  && seg >= bot;
        map_seg = map_ok ? 6'(seg) : 6'd0;
        map_com = 3'(per - 1 - int'(k) % per);
    end
    wire disp_wr = data_wr & map_ok;

    // Bit counter and address capture, LSB first
    always_ff @(posedge I_CLK) begin
        if (clr | cs_up) begin
            bit_reg  <= 6'd0;
            if (clr) addr_reg <= 4'h0;
        end else if (sck_up & ~rd_reg) begin
            if (in_addr)
                addr_reg[bit_reg[1:0]] <= din;
            if (bit_reg != 6'h3f)
                bit_reg <= bit_reg + 6'd1;
        end
    end

    // Control words; only the bits received are changed
    always_ff @(posedge I_CLK) begin
        if (clr) begin
            cfg_reg <= lks_pkg::CTRL_RESET;
            ctl_reg <= lks_pkg::CTRL_RESET;
        end else begin
            if (cfg_wr)
                cfg_reg[k[2:0]] <= cfg_keep ? 1'b0 : din;
            if (ctl_wr)
                ctl_reg[k[2:0]] <= din;
        end
    end

    // Display memory, one bit written per strobe
    always_ff @(posedge I_CLK) begin
        if (clr) begin
            for (int s = 0; s < lks_pkg::SEG_COUNT; s++)
                lit_reg[s] <= 8'h00;
        end else if (disp_wr) begin
            lit_reg[map_seg][map_com] <= din;
        end
    end

    // ------------------------------------------------------------
    // Key readout over the serial output
    // ------------------------------------------------------------
    logic [39:0] key_std_reg, key_exp_reg;

    // Arm on chip select fall after address only, drive after rise
    always_ff @(posedge I_CLK) begin
        if (clr) begin
            arm_reg    <= 1'b0;
            rd_reg     <= 1'b0;
            out_sh_reg <= 40'h0;
        end else if (cs_dn) begin
            arm_reg <= key_addr & (bit_reg == 6'(lks_pkg::ADDR_BITS));
            rd_reg  <= 1'b0;
        end else if (cs_up & arm_reg) begin
            arm_reg    <= 1'b0;
            rd_reg     <= 1'b1;
            out_sh_reg <= addr_reg[0] ? key_exp_reg : key_std_reg;
        end else if (sck_dn & rd_reg) begin
            out_sh_reg <= {1'b0, out_sh_reg[39:1]};
        end
    end

    assign LINK.dout      = rd_reg & cs & out_sh_reg[0];
    assign LINK.dout_oe_n = ~(rd_reg & cs);

    // ------------------------------------------------------------
    // Timebase, backplane slot and key scan
    // ------------------------------------------------------------
    logic [7:0] div_reg;
    logic [2:0] slot_reg;
    logic [4:0] scan_reg;
    logic       upd_reg;
    logic [7:0] hit_reg [lks_pkg::SCAN_LINES];

    wire       active   = run & ~clr;
    wire       int_tick = div_reg == 8'(OSC_DIV - 1);
    wire       tick     = active & (cfg_reg[lks_pkg::CFG_EXT_TB] ? tb_up
                                                                : int_tick);
    wire [2:0] line     = scan_reg[4:2];
    wire [7:0] line_oh  = 8'h01 << line;
    wire       sample   = tick & (scan_reg[1:0] == 2'(lks_pkg::SLOT_TICKS-1));
    wire [2:0] slot_nx  = ratio ? slot_reg + 3'd1 : {1'b0, slot_reg[1:0] + 2'd1};

    // Oscillator halts when not running
    always_ff @(posedge I_CLK) begin
        if (~active | int_tick)
            div_reg <= 8'h00;
        else
            div_reg <= div_reg + 8'h01;
    end

    // Slot and 32-tick scan cycle
    always_ff @(posedge I_CLK) begin
        if (clr) begin
            slot_reg <= 3'd0;
            scan_reg <= 5'd0;
            upd_reg  <= 1'b0;
        end else begin
            upd_reg <= tick & (scan_reg == 5'(lks_pkg::SCAN_PERIOD - 1));
            if (tick) begin
                slot_reg <= slot_nx;
                scan_reg <= scan_reg + 5'd1;
            end
        end
    end

    // Undriven lines read the pressed keys of the driven one
    always_ff @(posedge I_CLK) begin
        if (clr) begin
            for (int i = 0; i < lks_pkg::SCAN_LINES; i++)
                hit_reg[i] <= 8'h00;
        end else if (sample) begin
            hit_reg[line] <= key_in & ~line_oh;
        end
    end

    // Pairs i<j give standard keys, reverse pairs the diode keys
    logic [39:0] std_nx, exp_nx;
    always_comb begin
        int n;
        n      = 1;
        std_nx = 40'h0;
        exp_nx = 40'h0;
        for (int i = 0; i < lks_pkg::SCAN_LINES; i++) begin
            for (int j = i + 1; j < lks_pkg::SCAN_LINES; j++) begin
                std_nx[n] = hit_reg[i][j];
                exp_nx[n] = hit_reg[j][i];
                n = n + 1;
            end
        end
        std_nx[0] = |{std_nx, exp_nx};
        exp_nx[0] = std_nx[0];
    end

    // Key words refresh one cycle after each scan cycle
    always_ff @(posedge I_CLK) begin
        if (clr) begin
            key_std_reg <= 40'h0;
            key_exp_reg <= 40'h0;
        end else if (upd_reg) begin
            key_std_reg <= std_nx;
            key_exp_reg <= exp_nx;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic [43:0] seg_nx;
    logic [3:0]  bp_nx;
    always_comb begin
        for (int s = 0; s < lks_pkg::SEG_COUNT; s++)
            seg_nx[s] = ctl_reg[lks_pkg::CTL_DARK] ? 1'b0 :
                        ctl_reg[lks_pkg::CTL_LIT]  ? 1'b1 :
                        lit_reg[s][slot_reg];
        for (int c = 0; c < 4; c++) begin
            bp_nx[c] = slot_reg == 3'(c);
            if (ratio)
                seg_nx[c] = slot_reg == 3'(c + 4);
        end
        if (~active) begin
            seg_nx = 44'h0;
            bp_nx  = 4'h0;
        end
        for (int a = 0; a < lks_pkg::AUX_PINS; a++)
            if (cfg_reg[lks_pkg::CFG_AUX_SEL + a] & ~clr)
                seg_nx[43 - a] = ctl_reg[lks_pkg::CTL_AUX_LVL + a];
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_SEGMENT_LINES        <= 44'h0;
            O_BACKPLANE_DRIVES     <= 4'h0;
            O_KEY_SCAN_LINES       <= 8'h00;
            O_KEY_SCAN_LINES_OE_N  <= 8'h00;
            O_BIAS_LADDER_STRENGTH <= 1'b0;
        end else begin
            O_SEGMENT_LINES        <= seg_nx;
            O_BACKPLANE_DRIVES     <= bp_nx;
            O_KEY_SCAN_LINES       <= active ? line_oh : 8'h00;
            O_KEY_SCAN_LINES_OE_N  <= active ? ~line_oh : 8'h00;
            O_BIAS_LADDER_STRENGTH <= ctl_reg[lks_pkg::CTL_BIAS];
        end
    end
endmodule

// ---- design/lks_host.sv ----
`timescale 1ns/10ps
module lks_host (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    lks_link_if.host         LINK,
    input  wire logic [4:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    output logic      [31:0] O_AVS_READDATA,
    output logic             O_AVS_WAITREQUEST
);
    typedef enum {H_IDLE, H_LOW, H_HIGH, H_GAP, H_TAIL} lks_hstate_e;
    localparam int HALF = lks_pkg::LINK_HALF_CYC;

    lks_hstate_e st_reg;
    logic [7:0]  tm_reg;
    logic [5:0]  bit_reg, last_reg, rbits_reg;
    logic        rdph_reg, read_reg, hrst_reg, ack_reg;
    logic [43:0] sh_reg;
    logic [39:0] wd_reg, rd_reg;
    logic [1:0]  dsync_reg;

    // ------------------------------------------------------------
    // Register slave, one wait cycle per access
    // ------------------------------------------------------------
    wire acc    = I_AVS_READ | I_AVS_WRITE;
    wire take   = acc & ack_reg;
    wire busy   = st_reg != H_IDLE;
    wire go     = take & I_AVS_WRITE & (I_AVS_ADDRESS == lks_pkg::HREG_CMD)
                  & ~busy;
    wire [5:0] nbits = I_AVS_WRITEDATA[lks_pkg::CMD_NBITS +: 6];
    wire       rd_cmd = I_AVS_WRITEDATA[lks_pkg::CMD_READ];
    assign O_AVS_WAITREQUEST = acc & ~ack_reg;

    logic [31:0] rdata_nx;
    always_comb begin
        unique case (I_AVS_ADDRESS)
            lks_pkg::HREG_WD_LO:  rdata_nx = wd_reg[31:0];
            lks_pkg::HREG_WD_HI:  rdata_nx = {24'h0, wd_reg[39:32]};
            lks_pkg::HREG_STATUS: rdata_nx = {30'h0, hrst_reg, busy};
            lks_pkg::HREG_RD_LO:  rdata_nx = rd_reg[31:0];
            lks_pkg::HREG_RD_HI:  rdata_nx = {24'h0, rd_reg[39:32]};
            lks_pkg::HREG_HRESET: rdata_nx = {31'h0, hrst_reg};
            default:              rdata_nx = 32'h0;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ack_reg        <= 1'b0;
            O_AVS_READDATA <= 32'h0;
            wd_reg         <= 40'h0;
            hrst_reg       <= 1'b0;
        end else begin
            ack_reg <= acc & ~ack_reg;
            if (acc & ~ack_reg)
                O_AVS_READDATA <= rdata_nx;
            if (take & I_AVS_WRITE) begin
                if (I_AVS_ADDRESS == lks_pkg::HREG_WD_LO)
                    wd_reg[31:0] <= I_AVS_WRITEDATA;
                if (I_AVS_ADDRESS == lks_pkg::HREG_WD_HI)
                    wd_reg[39:32] <= I_AVS_WRITEDATA[7:0];
                if (I_AVS_ADDRESS == lks_pkg::HREG_HRESET)
                    hrst_reg <= I_AVS_WRITEDATA[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Link sequencer; strobe made by dividing the own clock
    // ------------------------------------------------------------
    wire tm_end = tm_reg == 8'(HALF - 1);
    wire last   = bit_reg == last_reg;

    // Serial output sampled through two flip-flops
    always_ff @(posedge I_CLK) begin
        dsync_reg <= {dsync_reg[0], LINK.dout & ~LINK.dout_oe_n};
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            st_reg   <= H_IDLE;
            tm_reg   <= 8'h00;
            bit_reg  <= 6'd0;
            last_reg <= 6'd0;
            rdph_reg <= 1'b0;
            read_reg <= 1'b0;
            sh_reg   <= 44'h0;
            rd_reg   <= 40'h0;
        end else begin
            tm_reg <= (st_reg == H_IDLE | tm_end) ? 8'h00 : tm_reg + 8'h01;
            unique case (st_reg)
                H_IDLE: if (go) begin
                    st_reg   <= H_LOW;
                    bit_reg  <= 6'd0;
                    rdph_reg <= 1'b0;
                    read_reg <= rd_cmd;
                    sh_reg   <= {wd_reg, I_AVS_WRITEDATA[3:0]};
                    last_reg <= rd_cmd ? 6'd3 : nbits + 6'd3;
                    if (rd_cmd) rd_reg <= 40'h0;
                end
                H_LOW: if (tm_end) st_reg <= H_HIGH;
                H_HIGH: if (tm_end) begin
                    if (rdph_reg) rd_reg[bit_reg] <= dsync_reg[1];
                    bit_reg <= bit_reg + 6'd1;
                    if (!last)
                        st_reg <= H_LOW;
                    else if (read_reg & ~rdph_reg)
                        st_reg <= H_GAP;
                    else
                        st_reg <= H_TAIL;
                end
                H_GAP: if (tm_end) begin
                    st_reg   <= H_LOW;
                    rdph_reg <= 1'b1;
                    bit_reg  <= 6'd0;
                end
                H_TAIL: if (tm_end) st_reg <= H_IDLE;
            endcase
            if (go & rd_cmd)
                last_reg <= 6'd3;
            if (st_reg == H_GAP & tm_end)
                last_reg <= rbits_reg - 6'd1;
        end
    end

    // Number of key bits to fetch, zero means one
    always_ff @(posedge I_CLK) begin
        if (I_RESET)
            rbits_reg <= 6'd1;
        else if (go)
            rbits_reg <= (nbits == 6'd0) ? 6'd1 : nbits;
    end

    assign LINK.hard_reset_n        = ~hrst_reg;
    assign LINK.cs                  = st_reg == H_LOW | st_reg == H_HIGH
                                      | st_reg == H_TAIL;
    assign LINK.serial_shift_strobe = st_reg == H_HIGH;
    assign LINK.din = ~rdph_reg & (st_reg == H_LOW | st_reg == H_HIGH)
                      & sh_reg[bit_reg];
endmodule

// ---- design/lks_link_if.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Four-wire link plus hard reset
// ----------------------------------------------------------------
interface lks_link_if;
    logic hard_reset_n;
    logic cs;
    logic serial_shift_strobe;
    logic din;
    logic dout;
    logic dout_oe_n;

    modport dev (
        input  hard_reset_n,
        input  cs,
        input  serial_shift_strobe,
        input  din,
        output dout,
        output dout_oe_n
    );
    modport host (
        output hard_reset_n,
        output cs,
        output serial_shift_strobe,
        output din,
        input  dout,
        input  dout_oe_n
    );
endinterface

// ---- design/lks_pkg.sv ----
package lks_pkg;
    // ------------------------------------------------------------
    // Address map of the driver
    // ------------------------------------------------------------
    localparam int           ADDR_BITS     = 4;
    localparam logic [3:0]   ADDR_QUAD_LAST = 4'h4;
    localparam logic [3:0]   ADDR_OCT_LAST  = 4'h7;
    localparam logic [3:0]   ADDR_CFG      = 4'h8;
    localparam logic [3:0]   ADDR_CTL      = 4'h9;
    localparam logic [3:0]   ADDR_KEY_STD  = 4'ha;
    localparam logic [3:0]   ADDR_KEY_EXP  = 4'hb;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int SEG_COUNT   = 44;
    localparam int COM_COUNT   = 8;
    localparam int SCAN_LINES  = 8;
    localparam int KEY_PAIRS   = 28;
    localparam int KEY_WORD    = 40;
    localparam int CTRL_WIDTH  = 8;
    localparam int AUX_PINS    = 4;
    localparam int SCAN_PERIOD = 32;
    localparam int SLOT_TICKS  = SCAN_PERIOD / SCAN_LINES;

    // ------------------------------------------------------------
    // Field positions of addresses 8 and 9, reset value
    // ------------------------------------------------------------
    localparam int CFG_EXT_TB  = 0;
    localparam int CFG_RATIO   = 3;
    localparam int CFG_AUX_SEL = 4;
    localparam int CTL_BIAS    = 0;
    localparam int CTL_LIT     = 1;
    localparam int CTL_DARK    = 2;
    localparam int CTL_RUN     = 3;
    localparam int CTL_AUX_LVL = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int LINK_PERIOD_NS = 800;
    localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int OSC_DIV_DEF    = 20;

    // ------------------------------------------------------------
    // Controller register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] HREG_CMD     = 5'h00;
    localparam logic [4:0] HREG_WD_LO   = 5'h04;
    localparam logic [4:0] HREG_WD_HI   = 5'h08;
    localparam logic [4:0] HREG_STATUS  = 5'h0c;
    localparam logic [4:0] HREG_RD_LO   = 5'h10;
    localparam logic [4:0] HREG_RD_HI   = 5'h14;
    localparam logic [4:0] HREG_HRESET  = 5'h18;
    localparam int CMD_READ  = 4;
    localparam int CMD_NBITS = 5;
endpackage

// ---- test/lks_link_asserts.sv ----
`timescale 1ns/10ps
module lks_link_asserts (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic hard_reset_n,
    input wire logic cs,
    input wire logic serial_shift_strobe,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe_n
);
    logic [2:0] nb_reg;
    logic [3:0] ad_reg;
    logic       rd_reg;

    // Bit count per frame, key-read arming on chip select fall
    always_ff @(posedge I_CLK) begin
        if (I_RESET || !hard_reset_n) begin
            nb_reg <= 3'h0;
            rd_reg <= 1'b0;
        end else if ($fell(cs)) begin
            nb_reg <= 3'h0;
            rd_reg <= !rd_reg && nb_reg == 3'h4 && ad_reg[3:1] == 3'h5;
        end else if (cs && $rose(serial_shift_strobe) && nb_reg != 3'h7) begin
            nb_reg <= nb_reg + 3'h1;
        end
    end

    // Address nibble capture, first bit is bit 0
    always_ff @(posedge I_CLK) begin
        if (cs && $rose(serial_shift_strobe) && !nb_reg[2]) begin
            ad_reg[nb_reg[1:0]] <= din;
        end
    end

    default clocking dc @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);

    chk_idle_strobe: assert property (!cs |-> !serial_shift_strobe)
        else $error("Strobe moved with chip select low");
    chk_frame_start: assert property (
        $rose(cs) |-> !serial_shift_strobe [*4])
        else $error("Strobe rose too early in frame");
    chk_strobe_high: assert property ($rose(serial_shift_strobe) |->
        serial_shift_strobe [*4] ##1 !serial_shift_strobe)
        else $error("Strobe high half wrong length");
    chk_strobe_low: assert property (
        $fell(serial_shift_strobe) |-> !serial_shift_strobe [*4])
        else $error("Strobe low half too short");
    chk_din_hold: assert property (
        serial_shift_strobe && $past(serial_shift_strobe) |-> $stable(din))
        else $error("Data moved while strobe high");
    chk_reset_quiet: assert property (!hard_reset_n [*3] |-> dout_oe_n)
        else $error("Output driven during hard reset");
    chk_hiz_shift: assert property (
        cs && !rd_reg && nb_reg != 3'h0 |-> dout_oe_n)
        else $error("Output driven while shifting in");
    chk_read_drive: assert property (
        rd_reg && serial_shift_strobe |-> !dout_oe_n)
        else $error("Output not driven in key read");

    cover property (rd_reg && serial_shift_strobe);
    cover property (!hard_reset_n [*3]);
    cover property ($fell(cs) && nb_reg == 3'h7);
endmodule

// ---- test/test_lcd_key_serial_address_map.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_lcd_key_serial_address_map;
    logic        I_CLK   = 1'b0;
    logic        I_RESET = 1'b1;
    logic [4:0]  av_a    = 5'h00;
    logic        av_r    = 1'b0;
    logic        av_w    = 1'b0;
    logic [31:0] av_d    = 32'h0;
    logic [31:0] av_q, q;
    logic        av_wait, bias;
    logic [2:0]  tdiv    = 3'h0;
    logic        kd      = 1'b0;
    logic [7:0]  ks_in, ks_out, ks_oe_n, drv;
    logic [43:0] seg;
    logic [3:0]  bp, exp_aux;
    logic [15:0] rows [4] = '{16'h3050, 16'hc8a0, 16'h0001, 16'hf0f1};
    int          num_errors = 0;
    int          n_tests    = 0;

    lks_link_if link ();
    lks_host lks_host_i (.I_CLK(I_CLK), .I_RESET(I_RESET), .LINK(link),
        .I_AVS_ADDRESS(av_a), .I_AVS_READ(av_r), .I_AVS_WRITE(av_w),
        .I_AVS_WRITEDATA(av_d), .O_AVS_READDATA(av_q),
        .O_AVS_WAITREQUEST(av_wait));
    lks_device #(.OSC_DIV(2)) lks_device_i (.I_CLK(I_CLK), .I_RESET(I_RESET),
        .LINK(link), .I_EXT_TIMEBASE(tdiv[2]), .I_KEY_SCAN_LINES(ks_in),
        .O_KEY_SCAN_LINES(ks_out), .O_KEY_SCAN_LINES_OE_N(ks_oe_n),
        .O_SEGMENT_LINES(seg), .O_BACKPLANE_DRIVES(bp),
        .O_BIAS_LADDER_STRENGTH(bias));
    lks_link_asserts lks_link_asserts_i (.I_CLK(I_CLK), .I_RESET(I_RESET),
        .hard_reset_n(link.hard_reset_n), .cs(link.cs),
        .serial_shift_strobe(link.serial_shift_strobe), .din(link.din),
        .dout(link.dout), .dout_oe_n(link.dout_oe_n));

    // Clock, 800 ns external timebase, key between lines 6 and 7
    always #50 I_CLK = ~I_CLK;
    always @(posedge I_CLK) tdiv <= tdiv + 3'h1;
    assign drv = ks_out & ~ks_oe_n;
    assign ks_in = drv | {drv[6], 7'h0} | {1'b0, drv[7] & !kd, 6'h0};

    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One bus cycle, held until waitrequest is low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge I_CLK);
        av_a <= a;
        av_d <= d;
        av_w <= w;
        av_r <= !w;
        do begin
            @(posedge I_CLK);
            n++;
        end while (av_wait !== 1'b0 && n < 20);
        q = av_q;
        av_r <= 1'b0;
        av_w <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    // One link transfer, polled until not busy
    task automatic xfer(input logic [3:0] a, input logic r,
                        input logic [5:0] nb, input logic [39:0] d);
        int n = 0;
        bus(1'b1, lks_pkg::HREG_WD_LO, d[31:0]);
        bus(1'b1, lks_pkg::HREG_WD_HI, {24'h0, d[39:32]});
        bus(1'b1, lks_pkg::HREG_CMD, {21'h0, nb, r, a});
        do begin
            bus(1'b0, lks_pkg::HREG_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 400);
        if (n >= 400) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    initial begin
        repeat (6) @(posedge I_CLK);
        I_RESET <= 1'b0;
        bus(1'b0, lks_pkg::HREG_STATUS, 32'h0);
        `CHK("status", 32'h0, q)
        bus(1'b0, 5'h1c, 32'h0);
        `CHK("unmapped", 32'h0, q)
        `CHK("outputs", 44'h0, seg)
        foreach (rows[i]) begin
            xfer(lks_pkg::ADDR_CFG, 1'b0, 6'h08, {32'h0, rows[i][15:8]});
            xfer(lks_pkg::ADDR_CTL, 1'b0, 6'h08, {32'h0, rows[i][7:0]});
            for (int k = 0; k < 4; k++) begin
                exp_aux[3-k] = rows[i][12+k] & rows[i][4+k];
            end
            repeat (4) @(posedge I_CLK);
            `CHK("aux", exp_aux, seg[43:40])
            `CHK("bias", rows[i][0], bias)
            `CHK("segments", 40'h0, seg[39:0])
        end
        bus(1'b1, lks_pkg::HREG_HRESET, 32'h1);
        repeat (8) @(posedge I_CLK);
        bus(1'b0, lks_pkg::HREG_STATUS, 32'h0);
        `CHK("held", 1'b1, q[1])
        `CHK("forced low", 44'h0, seg)
        bus(1'b1, lks_pkg::HREG_HRESET, 32'h0);
        repeat (8) @(posedge I_CLK);
        `CHK("cleared", 45'h0, {bias, seg})
        for (int m = 0; m < 2; m++) begin
            kd <= m[0];
            xfer(lks_pkg::ADDR_CFG, 1'b0, 6'h08, {39'h0, m[0]});
            xfer(lks_pkg::ADDR_CTL, 1'b0, 6'h08, 40'h08);
            repeat (900) @(posedge I_CLK);
            `CHK("one line", 1'b1, $onehot(drv))
            for (int w = 0; w < 2; w++) begin
                xfer({3'h5, w[0]}, 1'b1, 6'h28, 40'h0);
                bus(1'b0, lks_pkg::HREG_RD_LO, 32'h0);
                `CHK("key", (w == 0 || m == 0) ? 32'h10000001 : 32'h1, q)
            end
        end
        xfer(lks_pkg::ADDR_CTL, 1'b0, 6'h08, 40'h0);
        repeat (8) @(posedge I_CLK);
        `CHK("scan off", 20'h0, {ks_out, ks_oe_n, bp})
        tally_and_finish();
    end
endmodule
